// ===== core/charger_telemetry_readback.sv
// Telemetry and configuration readback register bank of the charger
`timescale 1ns/1ps
`include "telemetry_defines.svh"
// Notes on behaviour
// R1 - 0x3D holds signed battery current word; negative means discharging
// R2 - 0x3E holds input current word, same scaling as battery current
// R3 - 0x3F holds signed die temperature word
// R4 - 0x40 holds signed thermistor ratio word; hotter gives lower code
// R5 - 0x41 holds computed per-cell battery series resistance word
// R6 - 0x42 holds 3-bit temperature region from ratio versus thresholds
// R7 - 0x43 bits 11:8 decode two three-level chemistry straps to 0..8
// R8 - 0x43 bits 3:0 decode cell straps; twelve cells only for lead-acid
// R9 - 0x44 shows 5-bit charge current code, ramped one step at a time
// R10 - Sense servo voltage is charge current code plus one, in mV
// R11 - 0x45 shows 6-bit charge voltage code from setting and offsets
// R12 - 0x46 shows 6-bit input limit code following its setting
// R13 - 0x47 holds digitally filtered battery voltage word
// R14 - 0x48 holds battery current used for the latest resistance result
// R15 - 0x4A bit 0 is one only while telemetry outputs are valid
// R16 - Host writes to this bank are ignored
// R17 - Each word updates whole, never mixing two conversions
module charger_telemetry_readback #(
  parameter int NT          = `NUM_THRESH,
  parameter int STEP_CYCLES = `RAMP_STEP_CYCLES
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic [7:0]       reg_sel,
  input  wire logic             reg_read,
  input  wire logic             reg_write,
  output logic      [15:0]      reg_rdata,
  output logic                  reg_ack,
  input  wire logic             meas_update,
  input  wire logic             meas_good,
  input  wire logic [15:0]      battery_current_in,
  input  wire logic [15:0]      input_current_in,
  input  wire logic [15:0]      chip_heat_in,
  input  wire logic [15:0]      thermistor_in,
  input  wire logic [15:0]      battery_voltage_in,
  input  wire logic             resistance_done,
  input  wire logic [15:0]      resistance_in,
  input  wire logic [15:0]      resistance_current_in,
  input  wire logic [3:0]       chemistry_strap_pins,
  input  wire logic [5:0]       cell_count_strap_pins,
  input  wire logic [NT*16-1:0] temperature_region_thresholds,
  input  wire logic             charger_active,
  input  wire logic [4:0]       programmed_charge_current,
  input  wire logic [5:0]       programmed_charge_voltage,
  input  wire logic             absorb_active,
  input  wire logic [5:0]       absorb_voltage_offset,
  input  wire logic             equalize_active,
  input  wire logic [5:0]       equalize_voltage_offset,
  input  wire logic             region_comp_en,
  input  wire logic [5:0]       region_voltage_drop,
  input  wire logic [5:0]       programmed_input_limit,
  output logic      [4:0]       charge_current_ref_code,
  output logic      [5:0]       charge_voltage_ref_code,
  output logic      [5:0]       input_limit_ref_code,
  output logic      [5:0]       charge_servo_mv,
  output logic                  strap_invalid
);
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [3:0] chem_decode(input logic [3:0] p);
    case (p)
      {`LVL_LOW,   `LVL_LOW}:   chem_decode = 4'h0;
      {`LVL_HIGH,  `LVL_HIGH}:  chem_decode = 4'h1;
      {`LVL_LOW,   `LVL_FLOAT}: chem_decode = 4'h2;
      {`LVL_FLOAT, `LVL_LOW}:   chem_decode = 4'h3;
      {`LVL_LOW,   `LVL_HIGH}:  chem_decode = 4'h4;
      {`LVL_HIGH,  `LVL_FLOAT}: chem_decode = 4'h5;
      {`LVL_FLOAT, `LVL_HIGH}:  chem_decode = 4'h6;
      {`LVL_FLOAT, `LVL_FLOAT}: chem_decode = `CHEM_LEAD_FIXED;
      {`LVL_HIGH,  `LVL_LOW}:   chem_decode = `CHEM_LEAD_PROG;
      default:                  chem_decode = `CHEM_BAD;
    endcase
  endfunction

  function automatic logic [3:0] cells_decode(input logic [5:0] p);
    case (p)
      {`LVL_LOW,  `LVL_LOW,   `LVL_HIGH}:  cells_decode = 4'h1;
      {`LVL_LOW,  `LVL_HIGH,  `LVL_LOW}:   cells_decode = 4'h2;
      {`LVL_LOW,  `LVL_HIGH,  `LVL_HIGH}:  cells_decode = 4'h3;
      {`LVL_LOW,  `LVL_LOW,   `LVL_FLOAT}: cells_decode = 4'h4;
      {`LVL_LOW,  `LVL_FLOAT, `LVL_LOW}:   cells_decode = 4'h5;
      {`LVL_LOW,  `LVL_HIGH,  `LVL_FLOAT}: cells_decode = 4'h6;
      {`LVL_LOW,  `LVL_FLOAT, `LVL_HIGH}:  cells_decode = 4'h7;
      {`LVL_LOW,  `LVL_FLOAT, `LVL_FLOAT}: cells_decode = 4'h8;
      {`LVL_HIGH, `LVL_LOW,   `LVL_LOW}:   cells_decode = 4'h9;
      {`LVL_HIGH, `LVL_HIGH,  `LVL_HIGH}:  cells_decode = `CELLS_TWELVE;
      default:                             cells_decode = `CELLS_INVALID;
    endcase
  endfunction

  function automatic logic is_lead(input logic [3:0] c);
    is_lead = (c == `CHEM_LEAD_FIXED) || (c == `CHEM_LEAD_PROG);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  telemetry_pkg::word_t battery_current_reg;
  telemetry_pkg::word_t input_current_reg;
  telemetry_pkg::word_t chip_heat_reg;
  telemetry_pkg::word_t thermistor_reg;
  telemetry_pkg::word_t series_res_reg;
  telemetry_pkg::word_t res_current_reg;
  telemetry_pkg::word_t smooth_voltage_reg;
  telemetry_pkg::word_t smooth_voltage_next;
  telemetry_pkg::word_t read_word;
  logic [2:0]  region_reg;
  logic [2:0]  region_next;
  logic [9:0]  strap_meta_reg;
  logic [9:0]  strap_sync_reg;
  logic [11:0] strap_word_reg;
  logic [11:0] strap_word_next;
  logic [5:0]  voltage_ref_reg;
  logic [5:0]  voltage_ref_next;
  logic [5:0]  input_lim_reg;
  logic        seen_update_reg;
  logic        valid_reg;
  logic [15:0] rdata_reg;
  logic        ack_reg;
  logic [4:0]  current_target;
  logic [4:0]  current_code;
  logic [NT-1:0] hotter_than;
  logic [16:0] filt_diff;
  logic [16:0] filt_step;
  logic [7:0]  volt_sum;
  logic [7:0]  volt_drop;
  logic [3:0]  chem_now;
  logic [3:0]  cells_raw;

  //////////////////////////////////////////////////////////////////////////
  // Straps are pad levels; two flops before any decode reads them
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      strap_meta_reg <= 10'h000;
      strap_sync_reg <= 10'h000;
    end else begin
      strap_meta_reg <= {cell_count_strap_pins, chemistry_strap_pins};
      strap_sync_reg <= strap_meta_reg;
    end
  end

  assign chem_now  = chem_decode(strap_sync_reg[3:0]); // R7
  assign cells_raw = cells_decode(strap_sync_reg[9:4]); // R8
  // Twelve cells on a lithium chemistry is reported as invalid
  assign strap_word_next = {chem_now, 4'h0,
    ((cells_raw == `CELLS_TWELVE) && !is_lead(chem_now)) ?
      `CELLS_INVALID : cells_raw}; // R8
  assign strap_invalid = (strap_word_reg[3:0] == `CELLS_INVALID);

  //////////////////////////////////////////////////////////////////////////
  // Region is one plus the number of thresholds the ratio sits below, or none for a lead-acid chemistry
  genvar gi;
  generate
    for (gi = 0; gi < NT; gi++) begin : g_thresh
      assign hotter_than[gi] = $signed(thermistor_reg) <
        $signed(temperature_region_thresholds[gi*16 +: 16]); // R6
    end
  endgenerate

  always_comb begin
    region_next = `REGION_COLDEST;
    for (int i = 0; i < NT; i++) begin
      region_next = region_next + {2'h0, hotter_than[i]};
    end
    if (is_lead(strap_word_reg[11:8])) region_next = `REGION_NONE; // R6
  end

  //////////////////////////////////////////////////////////////////////////
  // First sample loads the filter directly to avoid a long climb from zero
  assign filt_diff = {battery_voltage_in[15], battery_voltage_in} -
                     {smooth_voltage_reg[15], smooth_voltage_reg};
  assign filt_step = $signed(filt_diff) >>> `FILT_SHIFT;
  assign smooth_voltage_next = !seen_update_reg ? battery_voltage_in :
    16'({smooth_voltage_reg[15], smooth_voltage_reg} + filt_step); // R13

  //////////////////////////////////////////////////////////////////////////
  // Charging pauses in the coldest and hottest regions
  assign current_target = (charger_active &&
    region_reg != `REGION_COLDEST && region_reg != `REGION_HOTTEST) ?
    programmed_charge_current : 5'h00; // R9

  current_soft_ramp #(
    .W           (5),
    .STEP_CYCLES (STEP_CYCLES)
  ) u_ramp (
    .clock  (clock),
    .reset  (reset),
    .target (current_target),
    .code   (current_code)
  );

  assign charge_current_ref_code = current_code; // R9
  assign charge_servo_mv = {1'b0, current_code} + 6'h01; // R10

  // Voltage code saturates at both ends instead of wrapping
  assign volt_drop = (region_comp_en && (region_reg == `REGION_WARM ||
    region_reg == `REGION_HOT)) ? {2'h0, region_voltage_drop} : 8'h00;
  assign volt_sum = {2'h0, programmed_charge_voltage} +
    (absorb_active ? {2'h0, absorb_voltage_offset} : 8'h00) +
    (equalize_active ? {2'h0, equalize_voltage_offset} : 8'h00);
  assign voltage_ref_next = (volt_sum < volt_drop) ? 6'h00 :
    ((volt_sum - volt_drop) > 8'h3F) ? 6'h3F :
    6'(volt_sum - volt_drop); // R11

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      battery_current_reg <= 16'h0000;
      input_current_reg   <= 16'h0000;
      chip_heat_reg       <= 16'h0000;
      thermistor_reg      <= 16'h0000;
      smooth_voltage_reg  <= 16'h0000;
      seen_update_reg     <= 1'b0;
    end else if (meas_update) begin
      battery_current_reg <= battery_current_in; // R1 R17
      input_current_reg   <= input_current_in; // R2 R17
      chip_heat_reg       <= chip_heat_in; // R3 R17
      thermistor_reg      <= thermistor_in; // R4 R17
      smooth_voltage_reg  <= smooth_voltage_next; // R13
      seen_update_reg     <= 1'b1;
    end
  end

  // Result and its current are captured together so they always pair
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      series_res_reg  <= 16'h0000;
      res_current_reg <= 16'h0000;
    end else if (resistance_done) begin
      series_res_reg  <= resistance_in; // R5
      res_current_reg <= resistance_current_in; // R14
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      region_reg      <= `REGION_NONE;
      strap_word_reg  <= 12'h000;
      voltage_ref_reg <= 6'h00;
      input_lim_reg   <= 6'h00;
      valid_reg       <= 1'b0;
    end else begin
      region_reg      <= region_next;
      strap_word_reg  <= strap_word_next;
      voltage_ref_reg <= voltage_ref_next;
      input_lim_reg   <= programmed_input_limit; // R12
      valid_reg       <= meas_good && seen_update_reg; // R15
    end
  end

  assign charge_voltage_ref_code = voltage_ref_reg;
  assign input_limit_ref_code    = input_lim_reg;

  //////////////////////////////////////////////////////////////////////////
  // Writes are acknowledged but never touch any storage
  assign read_word =
    (reg_sel == `ADDR_BATTERY_CURRENT) ? battery_current_reg :
    (reg_sel == `ADDR_INPUT_CURRENT)   ? input_current_reg :
    (reg_sel == `ADDR_CHIP_HEAT)       ? chip_heat_reg :
    (reg_sel == `ADDR_THERMISTOR)      ? thermistor_reg :
    (reg_sel == `ADDR_SERIES_RES)      ? series_res_reg :
    (reg_sel == `ADDR_TEMP_REGION)     ? {13'h0000, region_reg} :
    (reg_sel == `ADDR_STRAP_DECODE)    ? {4'h0, strap_word_reg} :
    (reg_sel == `ADDR_CHARGE_I_REF)    ? {11'h000, 5'(current_code)} :
    (reg_sel == `ADDR_CHARGE_V_REF)    ? {10'h000, voltage_ref_reg} :
    (reg_sel == `ADDR_INPUT_LIM_REF)   ? {10'h000, input_lim_reg} :
    (reg_sel == `ADDR_SMOOTH_VOLTAGE)  ? smooth_voltage_reg :
    (reg_sel == `ADDR_RES_CURRENT)     ? res_current_reg :
    (reg_sel == `ADDR_VALID_FLAG)      ? {15'h0000, valid_reg} :
    16'h0000;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rdata_reg <= 16'h0000;
      ack_reg   <= 1'b0;
    end else begin
      if (reg_read) rdata_reg <= read_word; // R17
      ack_reg <= reg_read || reg_write; // R16
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_ack   = ack_reg;

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_read_of(logic [7:0] a);
    reg_read && reg_sel == a;
  endsequence

  property p_battery_read;
    s_read_of(`ADDR_BATTERY_CURRENT) |=>
      reg_ack && reg_rdata == $past(battery_current_reg);
  endproperty
  a_battery_read: assert property (p_battery_read) // R1
    else $error("battery current read returned wrong word");

  property p_input_capture;
    meas_update |=> input_current_reg == $past(input_current_in) &&
                    battery_current_reg == $past(battery_current_in);
  endproperty
  a_input_capture: assert property (p_input_capture) // R2
    else $error("input current word not captured from conversion");

  property p_heat_stable;
    !meas_update |=> $stable(chip_heat_reg) && $stable(thermistor_reg);
  endproperty
  a_heat_stable: assert property (p_heat_stable) // R17
    else $error("measurement word changed outside an update");

  property p_thermistor_capture;
    meas_update |=> thermistor_reg == $past(thermistor_in) &&
                    chip_heat_reg == $past(chip_heat_in);
  endproperty
  a_thermistor_capture: assert property (p_thermistor_capture) // R4
    else $error("thermistor or heat word not captured whole");

  property p_resistance_pair;
    resistance_done |=> series_res_reg == $past(resistance_in) &&
                        res_current_reg == $past(resistance_current_in);
  endproperty
  a_resistance_pair: assert property (p_resistance_pair) // R14
    else $error("resistance result and its current not paired");

  property p_lead_no_region;
    is_lead(strap_word_reg[11:8]) ##1 is_lead(strap_word_reg[11:8])
      |-> region_reg == `REGION_NONE;
  endproperty
  a_lead_no_region: assert property (p_lead_no_region) // R6
    else $error("region reported for a lead-acid chemistry");

  property p_twelve_lead_only;
    strap_word_reg[3:0] == `CELLS_TWELVE |->
      is_lead(strap_word_reg[11:8]);
  endproperty
  a_twelve_lead_only: assert property (p_twelve_lead_only) // R8
    else $error("twelve cells reported for a lithium chemistry");

  property p_input_limit_follows;
    $changed(programmed_input_limit) |=>
      input_limit_ref_code == $past(programmed_input_limit);
  endproperty
  a_input_limit_follows: assert property (p_input_limit_follows) // R12
    else $error("input limit code did not follow its setting");

  property p_plain_voltage;
    !absorb_active && !equalize_active && !region_comp_en |=>
      charge_voltage_ref_code == $past(programmed_charge_voltage);
  endproperty
  a_plain_voltage: assert property (p_plain_voltage) // R11
    else $error("charge voltage code differs from plain setting");

  property p_valid_needs_good;
    !meas_good |=> !valid_reg and
      (s_read_of(`ADDR_VALID_FLAG) |=> reg_ack && !reg_rdata[0]);
  endproperty
  a_valid_needs_good: assert property (p_valid_needs_good) // R15
    else $error("valid flag set while measurements not good");

  property p_first_filter_load;
    !seen_update_reg && meas_update |=>
      smooth_voltage_reg == $past(battery_voltage_in);
  endproperty
  a_first_filter_load: assert property (p_first_filter_load) // R13
    else $error("filter did not load first battery voltage");

  property p_write_ignored;
    reg_write && !reg_read |=> reg_ack && $stable(reg_rdata);
  endproperty
  a_write_ignored: assert property (p_write_ignored) // R16
    else $error("write disturbed readback data");
endmodule

// ===== inc/telemetry_defines.svh
// Offsets, field positions and timing counts of the telemetry readback bank
`ifndef TELEMETRY_DEFINES_SVH
`define TELEMETRY_DEFINES_SVH
`define ADDR_BATTERY_CURRENT 8'h3D
`define ADDR_INPUT_CURRENT   8'h3E
`define ADDR_CHIP_HEAT       8'h3F
`define ADDR_THERMISTOR      8'h40
`define ADDR_SERIES_RES      8'h41
`define ADDR_TEMP_REGION     8'h42
`define ADDR_STRAP_DECODE    8'h43
`define ADDR_CHARGE_I_REF    8'h44
`define ADDR_CHARGE_V_REF    8'h45
`define ADDR_INPUT_LIM_REF   8'h46
`define ADDR_SMOOTH_VOLTAGE  8'h47
`define ADDR_RES_CURRENT     8'h48
`define ADDR_VALID_FLAG      8'h4A
`define CHEM_LSB             8
`define CELLS_LSB            0
`define LVL_LOW              2'h0
`define LVL_HIGH             2'h1
`define LVL_FLOAT            2'h2
`define CHEM_LEAD_FIXED      4'h7
`define CHEM_LEAD_PROG       4'h8
`define CHEM_BAD             4'hF
`define CELLS_INVALID        4'h0
`define CELLS_TWELVE         4'hC
`define REGION_NONE          3'h0
`define REGION_COLDEST       3'h1
`define REGION_HOTTEST       3'h7
`define REGION_WARM          3'h5
`define REGION_HOT           3'h6
`define NUM_THRESH           6
`define FILT_SHIFT           4
`define CLK_PERIOD_NS        50
`define RAMP_STEP_NS         10000
`define RAMP_STEP_CYCLES \
  ((`RAMP_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ===== inc/telemetry_pkg.sv
// Types shared by the telemetry readback bank
package telemetry_pkg;
  typedef logic [1:0]  strap_level_t;
  typedef logic [15:0] word_t;
  typedef enum logic [1:0] {RAMP_HOLD, RAMP_UP, RAMP_DOWN} ramp_state_e;
endpackage

// ===== core/current_soft_ramp.sv
// Soft-start and soft-stop ramp of the charge current reference code
`timescale 1ns/1ps
`include "telemetry_defines.svh"
module current_soft_ramp #(
  parameter int W           = 5,
  parameter int STEP_CYCLES = `RAMP_STEP_CYCLES
) (
  input  wire logic         clock,
  input  wire logic         reset,
  input  wire logic [W-1:0] target,
  output logic      [W-1:0] code
);
  localparam logic [15:0] STEP_LAST = 16'(STEP_CYCLES - 1);

  telemetry_pkg::ramp_state_e state;
  logic [15:0]  count_reg;
  logic [15:0]  count_next;
  logic [W-1:0] code_reg;
  logic [W-1:0] code_next;
  wire          step_tick = (count_reg == STEP_LAST);

  //////////////////////////////////////////////////////////////////////////
  assign state = (code_reg < target) ? telemetry_pkg::RAMP_UP :
                 (code_reg > target) ? telemetry_pkg::RAMP_DOWN :
                 telemetry_pkg::RAMP_HOLD;

  // Counter restarts when settled so a new target waits one full step
  always_comb begin
    count_next = step_tick ? 16'h0000 : count_reg + 16'h0001;
    code_next  = code_reg;
    case (state)
      telemetry_pkg::RAMP_UP: begin
        if (step_tick) code_next = code_reg + 1'b1; // R9
      end
      telemetry_pkg::RAMP_DOWN: begin
        if (step_tick) code_next = code_reg - 1'b1; // R9
      end
      telemetry_pkg::RAMP_HOLD: begin
        count_next = 16'h0000;
      end
      default: begin
        count_next = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      count_reg <= 16'h0000;
      code_reg  <= '0;
    end else begin
      count_reg <= count_next;
      code_reg  <= code_next;
    end
  end

  assign code = code_reg;

  //////////////////////////////////////////////////////////////////////////
  sequence s_code_moves;
    ##1 $changed(code_reg);
  endsequence

  property p_ramp_single_step;
    @(posedge clock) disable iff (reset)
      s_code_moves |-> (code_reg == $past(code_reg) + 1'b1) ||
                       (code_reg == $past(code_reg) - 1'b1);
  endproperty
  a_ramp_single_step: assert property (p_ramp_single_step) // R9
    else $error("charge current code jumped by more than one");

  property p_ramp_paced;
    @(posedge clock) disable iff (reset)
      s_code_moves |-> $past(count_reg) == STEP_LAST;
  endproperty
  a_ramp_paced: assert property (p_ramp_paced) // R9
    else $error("charge current code stepped before its interval");
endmodule

// ===== test/host_model.sv
// Host controller model for the telemetry register port
`timescale 1ns/1ps
module host_model (
  input  wire logic        clock,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_ack,
  output logic      [7:0]  reg_sel,
  output logic             reg_read,
  output logic             reg_write
);
  initial begin
    reg_sel = 8'h00;
    reg_read = 1'b0;
    reg_write = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // One strobe per access; the sub-address is held until the ack is seen
  task automatic access(input logic [7:0] a, input logic wr,
                        output logic [15:0] d);
    int n;
    @(posedge clock);
    #2;
    reg_sel = a;
    reg_read = ~wr;
    reg_write = wr;
    @(posedge clock);
    #2;
    reg_read = 1'b0;
    reg_write = 1'b0;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (reg_ack !== 1'b1 && n < 8);
    d = (reg_ack === 1'b1) ? reg_rdata : 16'hXXXX;
    #2;
    // Scrambled once released so a stale decode cannot pass
    reg_sel = ~a;
  endtask
endmodule

// ===== test/tb_top.sv
// Self-checking bench for the telemetry readback register bank
`timescale 1ns/1ps
module tb_top;
  logic        clock = 1'b0, reset = 1'b1, meas_update = 1'b0;
  logic        meas_good = 1'b1, resistance_done = 1'b0;
  logic        charger_active = 1'b0, absorb_active = 1'b0;
  logic        equalize_active = 1'b0, region_comp_en = 1'b0;
  logic        reg_read, reg_write, reg_ack, strap_invalid;
  logic [7:0]  reg_sel;
  logic [15:0] reg_rdata, d, bat_i = 16'h0000, in_i = 16'h0000;
  logic [15:0] heat = 16'h0000, ratio = 16'h0000, volt = 16'h0000;
  logic [15:0] res = 16'h0000, res_i = 16'h0000;
  logic [3:0]  chem = 4'h0;
  logic [5:0]  cells = 6'h01, set_v = 6'h00, abs_v = 6'h00, eq_v = 6'h00;
  logic [5:0]  drop_v = 6'h00, lim = 6'h00, v_code, l_code, servo;
  logic [4:0]  set_i = 5'h00, i_code;
  logic [95:0] thr = {16'h03E8, 16'h07D0, 16'h0BB8, 16'h0FA0, 16'h1388,
                      16'h1770};
  int          errors = 0, comparisons = 0;

  charger_telemetry_readback #(.STEP_CYCLES(4)) u_charger_telemetry_readback (
    .clock(clock), .reset(reset), .reg_sel(reg_sel), .reg_read(reg_read),
    .reg_write(reg_write), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .meas_update(meas_update), .meas_good(meas_good),
    .battery_current_in(bat_i), .input_current_in(in_i),
    .chip_heat_in(heat), .thermistor_in(ratio), .battery_voltage_in(volt),
    .resistance_done(resistance_done), .resistance_in(res),
    .resistance_current_in(res_i), .chemistry_strap_pins(chem),
    .cell_count_strap_pins(cells), .temperature_region_thresholds(thr),
    .charger_active(charger_active), .programmed_charge_current(set_i),
    .programmed_charge_voltage(set_v), .absorb_active(absorb_active),
    .absorb_voltage_offset(abs_v), .equalize_active(equalize_active),
    .equalize_voltage_offset(eq_v), .region_comp_en(region_comp_en),
    .region_voltage_drop(drop_v), .programmed_input_limit(lim),
    .charge_current_ref_code(i_code), .charge_voltage_ref_code(v_code),
    .input_limit_ref_code(l_code), .charge_servo_mv(servo),
    .strap_invalid(strap_invalid));
  host_model u_host_model (.clock(clock), .reg_rdata(reg_rdata),
    .reg_ack(reg_ack), .reg_sel(reg_sel), .reg_read(reg_read),
    .reg_write(reg_write));

  initial begin
    forever #25 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] s, e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e, string n);
    u_host_model.access(a, 1'b0, d);
    chk(n, d, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask
  task automatic upd;
    meas_update = 1'b1;
    cyc(1);
    meas_update = 1'b0;
  endtask
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_meas;
    rd(8'h4A, 16'h0000, "valid before data");
    rd(8'h49, 16'h0000, "unmapped");
    bat_i = 16'hFF38;
    in_i = 16'h0C80;
    heat = 16'h2EEA;
    ratio = 16'h0DAC;
    volt = 16'h0100;
    upd;
    volt = 16'h0200;
    rd(8'h47, 16'h0100, "filter load");
    rd(8'h3D, 16'hFF38, "battery current");
    rd(8'h3E, 16'h0C80, "input current");
    rd(8'h3F, 16'h2EEA, "chip heat");
    rd(8'h40, 16'h0DAC, "divider ratio");
    rd(8'h42, 16'h0004, "region");
    rd(8'h4A, 16'h0001, "valid flag");
    // Second sample moves the filter a sixteenth of the way
    upd;
    cyc(2);
    rd(8'h47, 16'h0100 + 16'h0010, "filter step");
  endtask
  task automatic t_res_write;
    res = 16'h0123;
    res_i = 16'hFE70;
    resistance_done = 1'b1;
    cyc(1);
    resistance_done = 1'b0;
    u_host_model.access(8'h3D, 1'b1, d);
    rd(8'h3D, 16'hFF38, "after write");
    rd(8'h41, 16'h0123, "series resistance");
    rd(8'h48, 16'hFE70, "resistance current");
  endtask
  task automatic t_straps;
    logic [3:0] cp [9] = '{4'h0, 4'h5, 4'h2, 4'h8, 4'h1, 4'h6, 4'h9, 4'hA,
                           4'h4};
    logic [5:0] cl [13] = '{6'h00, 6'h01, 6'h04, 6'h05, 6'h02, 6'h08, 6'h06,
                            6'h09, 6'h0A, 6'h10, 6'h11, 6'h14, 6'h15};
    logic [3:0] cn [13] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
                            4'h8, 4'h9, 4'h0, 4'h0, 4'hC};
    for (int i = 0; i < 9; i++) begin
      chem = cp[i];
      cyc(4);
      rd(8'h43, {4'h0, i[3:0], 8'h01}, "chemistry");
    end
    rd(8'h42, 16'h0000, "region lead-acid");
    for (int i = 0; i < 13; i++) begin
      cells = cl[i];
      cyc(4);
      rd(8'h43, {8'h08, 4'h0, cn[i]}, "cell count");
      chk("strap invalid", {15'h0, strap_invalid},
          {15'h0, cn[i] == 4'h0});
    end
    chem = 4'h3;
    cyc(4);
    rd(8'h43, 16'h0F00, "chemistry bad");
    chem = 4'h0;
    cyc(4);
    rd(8'h43, 16'h0000, "twelve lithium");
  endtask
  task automatic t_refs;
    set_i = 5'h03;
    charger_active = 1'b1;
    cyc(6);
    chk("ramp midway", {11'h0, i_code}, 16'h0001);
    chk("servo", {10'h0, servo}, 16'h0002);
    cyc(20);
    rd(8'h44, 16'h0003, "ramp top");
    chk("servo top", {10'h0, servo}, 16'h0004);
    charger_active = 1'b0;
    set_v = 6'h10;
    abs_v = 6'h05;
    absorb_active = 1'b1;
    eq_v = 6'h02;
    equalize_active = 1'b1;
    // Region 4 must not take the drop
    region_comp_en = 1'b1;
    drop_v = 6'h08;
    lim = 6'h2A;
    cyc(30);
    rd(8'h44, 16'h0000, "ramp down");
    rd(8'h45, 16'h0017, "voltage sum");
    rd(8'h46, 16'h002A, "input limit");
    chk("voltage out", {10'h0, v_code}, 16'h0017);
    chk("limit out", {10'h0, l_code}, 16'h002A);
    set_v = 6'h3E;
    meas_good = 1'b0;
    cyc(3);
    rd(8'h45, 16'h003F, "voltage clamp");
    rd(8'h4A, 16'h0000, "valid dropped");
    // Warm region takes the drop off the clamped-free sum 0x45
    ratio = 16'h09C4;
    upd;
    cyc(3);
    rd(8'h42, 16'h0005, "region warm");
    rd(8'h45, 16'h003D, "voltage drop");
    chk("voltage out drop", {10'h0, v_code}, 16'h003D);
    // Hottest region holds the current code at zero
    ratio = 16'h0100;
    upd;
    cyc(3);
    charger_active = 1'b1;
    cyc(20);
    rd(8'h42, 16'h0007, "region hottest");
    rd(8'h44, 16'h0000, "hot pause");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clock);
    #2;
    reset = 1'b0;
    t_meas;
    t_res_write;
    t_straps;
    t_refs;
    finish_test;
  end
  initial begin
    #200000;
    errors++;
    finish_test;
  end
endmodule
